/* hdl/adc_pf_defines.vh */
// Register map, field positions, reset values and timing for the power-fail compare unit
`ifndef ADC_PF_DEFINES_VH
`define ADC_PF_DEFINES_VH
`define OFS_CTRL          8'h00
`define OFS_THRESHOLD     8'h04
`define OFS_THR_BITOP     8'h08
`define OFS_IRQ_STATUS    8'h0C
`define OFS_IRQ_CLEAR     8'h10
`define OFS_IRQ_ENABLE    8'h14
`define OFS_RESULT_BASE   8'h40
`define CTRL_RUN_BIT      0
`define CTRL_SCAN_BIT     1
`define CTRL_DIR_BIT      2
`define CTRL_SEL_LSB      8
`define CTRL_SEL_MSB      11
`define CTRL_BUSY_BIT     16
`define BITOP_IDX_MSB     2
`define BITOP_VAL_BIT     3
`define IRQ_END_BIT       0
`define IRQ_STORE_BIT     1
`define THRESHOLD_RST     8'h00
`define LAST_CHANNEL      4'hb
`define CONV_TIME_NS      2000
`define CLK_MHZ           50
`define CONV_CYCLES       ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

/* hdl/result_store.v */
// Conversion result memory with registered read data
`timescale 1ns/100ps
module result_store #(
  parameter WIDTH = 10,
  parameter DEPTH = 12,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];

  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule // result_store

/* hdl/adc_power_fail_compare.v */
// Power-fail compare unit with conversion sequencing and AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "adc_pf_defines.vh"
module adc_power_fail_compare #(
  parameter CONV_CYCLES = `CONV_CYCLES
) (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [9:0]  conversion_result,
  output reg  [3:0]  conv_chan,
  output wire        conv_busy,
  output wire        conversion_end_irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg        state_r;
  reg [15:0] cnt_r;
  reg        run_r;
  reg        scan_r;
  reg        compare_direction_select;
  reg [3:0]  channel_select;
  reg [7:0]  power_fail_threshold;
  reg [7:0]  channel_zero_high_byte;
  reg [1:0]  irq_status_r;
  reg [1:0]  irq_enable_r;
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg        rd_pend_r;
  reg [7:0]  araddr_r;
  wire [9:0] mem_rdata;

  // Match test on a result high byte against the threshold
  function pf_match;
    input [7:0] result_high_byte;
    input [7:0] thr;
    input       dir;
    begin
      pf_match = dir ? (result_high_byte < thr) : (result_high_byte >= thr);
    end
  endfunction

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !rd_pend_r && !s_axi_rvalid;
  assign conv_busy     = (state_r == ST_CONV);

  wire do_wr     = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_ctrl   = do_wr && (awaddr_r == `OFS_CTRL);
  wire wr_thr    = do_wr && (awaddr_r == `OFS_THRESHOLD) && wstrb_r[0];
  wire wr_bitop  = do_wr && (awaddr_r == `OFS_THR_BITOP) && wstrb_r[0];
  wire wr_clr    = do_wr && (awaddr_r == `OFS_IRQ_CLEAR);
  wire wr_en_irq = do_wr && (awaddr_r == `OFS_IRQ_ENABLE);
  wire wr_known  = (awaddr_r == `OFS_CTRL) || (awaddr_r == `OFS_THRESHOLD) ||
                   (awaddr_r == `OFS_THR_BITOP) || (awaddr_r == `OFS_IRQ_CLEAR) ||
                   (awaddr_r == `OFS_IRQ_ENABLE) || (awaddr_r == `OFS_IRQ_STATUS);

  // Conversion completion and its consequences
  // restart on a write to the control, threshold or threshold-bit register
  wire cfg_write  = wr_ctrl || wr_thr || wr_bitop;
  wire conv_done  = (state_r == ST_CONV) && (cnt_r == CONV_CYCLES - 1) && !cfg_write;
  wire [7:0] result_high_byte = conversion_result[9:2];
  wire [7:0] ch0_hb = (conv_chan == 4'h0) ? result_high_byte : channel_zero_high_byte;
  wire       scan_last = (conv_chan >= channel_select);
  wire       sel_match = pf_match(result_high_byte, power_fail_threshold,
                                  compare_direction_select);
  wire       scan_match = pf_match(ch0_hb, power_fail_threshold, compare_direction_select);
  wire       store_evt = conv_done && (scan_r || sel_match);
  wire       end_evt   = conv_done && (scan_r ? (scan_last && scan_match) : sel_match);
  wire [3:0] first_chan = scan_r ? 4'h0 : channel_select;

  result_store #(.WIDTH(10), .DEPTH(12), .AW(4)) u_store (
    .ref_clk (ref_clk),
    .wr_en   (store_evt),
    .wr_addr (conv_chan),
    .wr_data (conversion_result),
    .rd_addr (s_axi_araddr[5:2]),
    .rd_data (mem_rdata)
  );

  assign conversion_end_irq = |(irq_status_r & irq_enable_r);

  // Control and threshold registers
  always @(posedge ref_clk) begin
    if (srst) begin
      run_r                    <= 1'b0;
      scan_r                   <= 1'b0;
      compare_direction_select <= 1'b0;
      channel_select           <= 4'h0;
      power_fail_threshold     <= `THRESHOLD_RST;
      irq_enable_r             <= 2'b00;
      irq_status_r             <= 2'b00;
    end else begin
      if (wr_ctrl) begin
        run_r                    <= wdata_r[`CTRL_RUN_BIT];
        scan_r                   <= wdata_r[`CTRL_SCAN_BIT];
        compare_direction_select <= wdata_r[`CTRL_DIR_BIT];
        // Out-of-range channels clamp to the last one rather than alias
        channel_select <= (wdata_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB] > `LAST_CHANNEL) ?
                          `LAST_CHANNEL : wdata_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
      end
      if (wr_thr) begin
        power_fail_threshold <= wdata_r[7:0];
      end else if (wr_bitop) begin
        power_fail_threshold[wdata_r[`BITOP_IDX_MSB:0]] <= wdata_r[`BITOP_VAL_BIT];
      end
      if (wr_en_irq) begin
        irq_enable_r <= wdata_r[1:0];
      end
      // Set wins over a clear in the same cycle
      irq_status_r <= (irq_status_r & ~(wr_clr ? wdata_r[1:0] : 2'b00)) |
                      {store_evt, end_evt};
    end
  end

  // Conversion sequencer
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r                <= ST_IDLE;
      cnt_r                  <= 16'h0000;
      conv_chan              <= 4'h0;
      channel_zero_high_byte <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= 16'h0000;
          if (run_r && !cfg_write) begin
            state_r   <= ST_CONV;
            conv_chan <= first_chan;
          end
        end
        ST_CONV: begin
          if (!run_r) begin
            state_r <= ST_IDLE;
          end else if (cfg_write) begin
            // Abort and begin again from the first channel
            state_r <= ST_IDLE;
            cnt_r   <= 16'h0000;
          end else if (conv_done) begin
            cnt_r <= 16'h0000;
            if (conv_chan == 4'h0) begin
              channel_zero_high_byte <= result_high_byte;
            end
            if (scan_r && !scan_last) begin
              conv_chan <= conv_chan + 4'h1;
            end else begin
              conv_chan <= first_chan;
            end
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // AXI4-Lite write channels
  always @(posedge ref_clk) begin
    if (srst) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channels; one extra cycle lets the result memory answer
  always @(posedge ref_clk) begin
    if (srst) begin
      rd_pend_r    <= 1'b0;
      araddr_r     <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_r <= 1'b1;
        araddr_r  <= {s_axi_araddr[7:2], 2'b00};
      end
      if (rd_pend_r) begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (araddr_r >= `OFS_RESULT_BASE) begin
          if (araddr_r[5:2] <= `LAST_CHANNEL && araddr_r[7:6] == 2'b01) begin
            s_axi_rdata <= {22'h00_0000, mem_rdata};
          end else begin
            s_axi_rresp <= `RESP_SLVERR;
          end
        end else begin
          case (araddr_r)
            `OFS_CTRL: s_axi_rdata <= {15'h0000, conv_busy, 4'h0, channel_select,
                                       5'h00, compare_direction_select, scan_r, run_r};
            `OFS_THRESHOLD:  s_axi_rdata <= {24'h00_0000, power_fail_threshold};
            `OFS_IRQ_STATUS: s_axi_rdata <= {30'h0000_0000, irq_status_r};
            `OFS_IRQ_ENABLE: s_axi_rdata <= {30'h0000_0000, irq_enable_r};
            `OFS_THR_BITOP:  s_axi_rdata <= 32'h0000_0000;
            `OFS_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
            default:         s_axi_rresp <= `RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // adc_power_fail_compare

/* dv/adc_pf_checker.sv */
// Bus and behaviour assertions for the power-fail compare unit
`timescale 1ns/100ps
module adc_pf_checker (
  input wire        ref_clk,
  input wire        srst,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [3:0]  conv_chan,
  input wire        conv_busy,
  input wire        conversion_end_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_READ_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer late or early");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_WRITE_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with answer pending");
  AST_RESET_IDLE: assert property ($past(srst) |-> !conv_busy && conv_chan == 4'h0 && !conversion_end_irq)
    else $error("not idle after reset");
  // Both halves of the write are offered together by the bench
  AST_ABORT_ON_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[7:3] == 5'h00 && conv_busy |-> ##[1:3] !conv_busy)
    else $error("conversion not aborted by write");
  AST_IRQ_CAUSE: assert property ($rose(conversion_end_irq) |-> $past(conv_busy) || $rose(s_axi_bvalid))
    else $error("interrupt without conversion end");
  AST_CHAN_RANGE: assert property (conv_chan <= 4'hb)
    else $error("channel out of range");
endmodule // adc_pf_checker
bind adc_power_fail_compare adc_pf_checker u_adc_pf_checker (.*);

/* dv/tb_adc_power_fail_compare.sv */
// Self-checking bench for the power-fail compare unit
`timescale 1ns/100ps
`include "adc_pf_defines.vh"
`define CHK(nm, e, s) begin samples_checked = samples_checked + 1; if ((s) !== (e)) begin \
  num_errors = num_errors + 1; $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_adc_power_fail_compare;
  reg         ref_clk, srst, awv, wv, bready, arv, rready, ta, tw, tb;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, d;
  reg  [3:0]  wstrb;
  reg  [9:0]  res, kept;
  reg  [1:0]  r;
  reg  [19:0] rows [0:5];
  wire        awready, wready, bvalid, arready, rvalid, busy, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  chan;
  integer     num_errors, samples_checked, i, n;
  // Short conversion keeps each row to a few dozen cycles
  adc_power_fail_compare #(.CONV_CYCLES(4)) u_adc_power_fail_compare (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conversion_result(res), .conv_chan(chan), .conv_busy(busy), .conversion_end_irq(irq));
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Ready is sampled mid-cycle, where it equals its value at the next rising edge
  task wr(input [7:0] a, input [31:0] dd, input [3:0] s);
    begin
      @(posedge ref_clk);
      awaddr <= a; wdata <= dd; wstrb <= s; awv <= 1; wv <= 1; bready <= 1; tb = 0;
      for (n = 0; n < 99 && !tb; n = n + 1) begin
        @(negedge ref_clk);
        {ta, tw, tb, r} = {awready, wready, bvalid, bresp};
        @(posedge ref_clk);
        if (ta) awv <= 0;
        if (tw) wv <= 0;
        if (tb) bready <= 0;
      end
      if (!tb) begin num_errors = num_errors + 1; test_done; end
      @(negedge ref_clk);
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge ref_clk);
      araddr <= a; arv <= 1; rready <= 1; tb = 0;
      for (n = 0; n < 99 && !tb; n = n + 1) begin
        @(negedge ref_clk);
        {ta, tb, d, r} = {arready, rvalid, rdata, rresp};
        @(posedge ref_clk);
        if (ta) arv <= 0;
        if (tb) rready <= 0;
      end
      if (!tb) begin num_errors = num_errors + 1; test_done; end
    end
  endtask
  initial begin
    srst = 1; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0; res = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; num_errors = 0; samples_checked = 0;
    // Threshold, direction, result, expected match
    rows[0] = {8'h80, 1'b0, 10'h200, 1'b1};
    rows[1] = {8'h80, 1'b0, 10'h1ff, 1'b0};
    rows[2] = {8'h80, 1'b1, 10'h1ff, 1'b1};
    rows[3] = {8'h80, 1'b1, 10'h200, 1'b0};
    rows[4] = {8'h81, 1'b0, 10'h203, 1'b0};
    rows[5] = {8'h00, 1'b1, 10'h000, 1'b0};
    repeat (3) @(posedge ref_clk);
    srst <= 0;
    rd_reg(`OFS_THRESHOLD);
    `CHK("thr_reset", 32'h0000_0000, d)
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001, 4'hf);
    `CHK("bresp", `RESP_OKAY, r)
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge ref_clk) res <= rows[i][10:1];
      wr(`OFS_THRESHOLD, {24'h0, rows[i][19:12]}, 4'hf);
      wr(`OFS_CTRL, {20'h0, 4'h3, 5'h0, rows[i][11], 2'b01}, 4'hf);
      repeat (20) @(negedge ref_clk);
      `CHK("irq", rows[i][0], irq)
      `CHK("busy_chan", 5'h13, {busy, chan})
      wr(`OFS_CTRL, 32'h0000_0300, 4'hf);
      rd_reg(`OFS_IRQ_STATUS);
      `CHK("status", {30'h0, {2{rows[i][0]}}}, d)
      rd_reg(8'h4c);
      // A failing row must leave the last matching result in place
      if (rows[i][0]) kept = rows[i][10:1];
      `CHK("result", {22'h0, kept}, d)
      wr(`OFS_IRQ_CLEAR, 32'h0000_0003, 4'hf);
      $display("row %0d done", i);
    end
    wr(`OFS_THRESHOLD, 32'h0000_0000, 4'hf);
    wr(`OFS_THR_BITOP, 32'h0000_000f, 4'hf);
    wr(`OFS_THR_BITOP, 32'h0000_0008, 4'hf);
    wr(`OFS_THRESHOLD, 32'h0000_00ff, 4'he);
    rd_reg(`OFS_THRESHOLD);
    `CHK("bit_access", 32'h0000_0081, d)
    rd_reg(8'h3c);
    `CHK("unmapped", {`RESP_SLVERR, 32'h0000_0000}, {r, d})
    wr(8'h3c, 32'h0000_00ff, 4'hf);
    `CHK("bresp_unmapped", `RESP_SLVERR, r)
    $display("register test done");
    // Scan that fails the compare still stores every channel
    @(posedge ref_clk) res <= 10'h2aa;
    wr(`OFS_CTRL, 32'h0000_0107, 4'hf);
    repeat (30) @(negedge ref_clk);
    `CHK("scan_irq", 1'b0, irq)
    wr(`OFS_CTRL, 32'h0000_0000, 4'hf);
    rd_reg(`OFS_IRQ_STATUS);
    `CHK("scan_status", 32'h0000_0002, d)
    rd_reg(8'h44);
    `CHK("scan_result", 32'h0000_02aa, d)
    wr(`OFS_IRQ_ENABLE, 32'h0000_0002, 4'hf);
    `CHK("irq_enable", 1'b1, irq)
    wr(`OFS_IRQ_CLEAR, 32'h0000_0002, 4'hf);
    `CHK("irq_clear", 1'b0, irq)
    $display("scan test done");
    // Threshold write mid-scan aborts; the restarted scan then matches on channel 0
    wr(`OFS_IRQ_ENABLE, 32'h0000_0001, 4'hf);
    wr(`OFS_CTRL, 32'h0000_0107, 4'hf);
    repeat (10) @(negedge ref_clk);
    wr(`OFS_THRESHOLD, 32'h0000_00ff, 4'hf);
    repeat (30) @(negedge ref_clk);
    `CHK("scan_match_irq", 1'b1, irq)
    $display("scan match test done");
    // Reset in mid-run must return everything to idle
    @(posedge ref_clk) srst <= 1;
    repeat (2) @(posedge ref_clk);
    srst <= 0;
    @(negedge ref_clk);
    `CHK("reset_idle", 6'h00, {busy, irq, chan})
    rd_reg(`OFS_THRESHOLD);
    `CHK("thr_rerun", 32'h0000_0000, d)
    $display("reset test done");
    test_done;
  end
endmodule // tb_adc_power_fail_compare
